// ===== shared/sfb_pkg.sv
// constants and types for the serial flash boot master
// assumes a 100 MHz system clock and one serial flash in mode 0
// Behaviour
// - fast read: opcode 0x0B, three address bytes, one dummy, then continuous data
// - page program: opcode 0x02, three address bytes, then streamed data bytes
// - status write: opcode 0x01 and exactly one status byte, never two
// - hold and write-protect pins of the flash are never driven
// - during reset the clock, data out and primary select are released
// - reset leaves the secondary select pin unchanged
// - when operational, flash is programmed on command from the control port
// - the two-wire control port supports 100 kHz operation
// - the flash port uses serial clock polarity and phase mode 0
// - at boot: write enable, poll status until latch set, write zero status
// - before program or erase: write enable, poll until latch set, then command
package sfb_pkg;
	localparam logic [7:0] SFB_OP_FAST_READ = 8'h0B;
	localparam logic [7:0] SFB_OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] SFB_OP_STATUS_WR = 8'h01;
	localparam logic [7:0] SFB_OP_STATUS_RD = 8'h05;
	localparam logic [7:0] SFB_OP_WRITE_EN = 8'h06;
	localparam logic [7:0] SFB_OP_SECT_ERASE = 8'h20;
	localparam logic [7:0] SFB_OP_CHIP_ERASE = 8'hC7;
	localparam int SFB_LATCH_POS = 1;
	localparam logic [7:0] SFB_STATUS_CLEAR = 8'h00;
	// serial clock half period; 10 ns x 4 gives 12.5 MHz, inside 1.4..30.1 MHz
	localparam int SFB_CLK_NS = 10;
	localparam int SFB_HALF_NS = 40;
	localparam int SFB_HALF_CYC = (SFB_HALF_NS + SFB_CLK_NS - 1) / SFB_CLK_NS;
	localparam logic [1:0] SFB_CMD_READ = 2'h0;
	localparam logic [1:0] SFB_CMD_PROG = 2'h1;
	localparam logic [1:0] SFB_CMD_SERASE = 2'h2;
	localparam logic [1:0] SFB_CMD_CERASE = 2'h3;
	typedef enum logic [3:0] {
		SFB_BOOT = 4'b0000,
		SFB_IDLE = 4'b0001,
		SFB_WE_SENT = 4'b0010,
		SFB_POLL = 4'b0011,
		SFB_CHECK = 4'b0100,
		SFB_CLEAR_SENT = 4'b0101,
		SFB_MAIN = 4'b0110,
		SFB_STREAM = 4'b0111,
		SFB_DESEL = 4'b1000
	} sfb_state_t;
endpackage : sfb_pkg

// ===== core/sfb_master.sv
// serial flash boot master: boot unprotect, fast read, program and erase
// assumes the command port is driven on clk_sys by the two-wire control logic
`timescale 1ns/100ps
module sfb_master
	import sfb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_kind,
	input wire logic [23:0] cmd_addr,
	input wire logic cmd_stop,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic boot_done,
	output logic busy,
	input wire logic flash_select_secondary_in,
	output logic flash_serial_clock,
	output logic flash_serial_clock_oe_b,
	output logic flash_serial_data_out,
	output logic flash_serial_data_out_oe_b,
	output logic flash_select_primary_b,
	output logic flash_select_primary_oe_b,
	output logic flash_select_secondary_b,
	input wire logic flash_serial_data_in
);

	// ****************************************
	// state
	// ****************************************
	sfb_state_t state_reg, state_next;
	logic [1:0] kind_reg, kind_next;
	logic [23:0] addr_reg, addr_next;
	logic [39:0] sh_reg, sh_next;
	logic [5:0] bits_reg, bits_next;
	logic [7:0] rx_reg, rx_next;
	logic [7:0] rd_reg, rd_next;
	logic rdv_reg, rdv_next;
	logic sck_reg, sck_next;
	logic cs_reg, cs_next;
	logic [2:0] div_reg, div_next;
	logic boot_reg, boot_next;
	logic sec_reg;
	logic din_s1_reg, din_s2_reg;

	// secondary select keeps its own level, untouched by reset
	always_ff @(posedge clk_sys)
	begin
		sec_reg <= flash_select_secondary_in;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			din_s1_reg <= 1'b0;
			din_s2_reg <= 1'b0;
		end
		else
		begin
			din_s1_reg <= flash_serial_data_in;
			din_s2_reg <= din_s1_reg;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	// each frame of 1 to 5 bytes: load sh, set bits, drive select low
	logic tick;
	logic [7:0] rx_shift;
	always_comb
	begin
		state_next = state_reg;
		kind_next = kind_reg;
		addr_next = addr_reg;
		sh_next = sh_reg;
		bits_next = bits_reg;
		rx_next = rx_reg;
		rd_next = rd_reg;
		rdv_next = 1'b0;
		sck_next = sck_reg;
		cs_next = cs_reg;
		div_next = div_reg;
		boot_next = boot_reg;
		cmd_ready = 1'b0;
		wr_ready = 1'b0;
		tick = (div_reg == 3'(SFB_HALF_CYC - 1));
		rx_shift = {rx_reg[6:0], din_s2_reg};
		if (bits_reg != 6'd0)
		begin
			div_next = tick ? 3'd0 : div_reg + 3'd1;
			if (tick)
			begin
				if (!sck_reg)
				begin
					// mode 0: data sampled on rising edge
					sck_next = 1'b1;
					rx_next = rx_shift;
				end
				else
				begin
					// data changes on falling edge
					sck_next = 1'b0;
					sh_next = {sh_reg[38:0], 1'b0};
					bits_next = bits_reg - 6'd1;
				end
			end
		end
		else
		begin
			case (state_reg)
				SFB_BOOT:
				begin
					cs_next = 1'b0;
					sh_next = {SFB_OP_WRITE_EN, 32'h0000_0000};
					bits_next = 6'd8;
					state_next = SFB_WE_SENT;
				end
				SFB_WE_SENT:
				begin
					cs_next = 1'b1;
					state_next = SFB_DESEL;
				end
				SFB_DESEL:
				begin
					// status read: opcode, two unused slots, status in fourth
					cs_next = 1'b0;
					sh_next = {SFB_OP_STATUS_RD, 32'h0000_0000};
					bits_next = 6'd32;
					state_next = SFB_POLL;
				end
				SFB_POLL:
				begin
					cs_next = 1'b1;
					state_next = SFB_CHECK;
				end
				SFB_CHECK:
				begin
					if (!rx_reg[SFB_LATCH_POS])
					begin
						state_next = SFB_DESEL;
					end
					else if (!boot_reg)
					begin
						cs_next = 1'b0;
						// single status byte only, no expansion byte
						sh_next = {SFB_OP_STATUS_WR, SFB_STATUS_CLEAR, 24'h00_0000};
						bits_next = 6'd16;
						state_next = SFB_CLEAR_SENT;
					end
					else
					begin
						cs_next = 1'b0;
						bits_next = (kind_reg == SFB_CMD_CERASE) ? 6'd8 : 6'd32;
						case (kind_reg)
							SFB_CMD_PROG: sh_next = {SFB_OP_PAGE_PROG, addr_reg, 8'h00};
							SFB_CMD_SERASE: sh_next = {SFB_OP_SECT_ERASE, addr_reg, 8'h00};
							default: sh_next = {SFB_OP_CHIP_ERASE, 32'h0000_0000};
						endcase
						state_next = SFB_MAIN;
					end
				end
				SFB_CLEAR_SENT:
				begin
					cs_next = 1'b1;
					boot_next = 1'b1;
					state_next = SFB_IDLE;
				end
				SFB_IDLE:
				begin
					// ready on each idle clock, one command per finished flash frame; the 100 kHz control bus is far slower
					cmd_ready = 1'b1;
					if (cmd_valid)
					begin
						kind_next = cmd_kind;
						addr_next = cmd_addr;
						cs_next = 1'b0;
						if (cmd_kind == SFB_CMD_READ)
						begin
							sh_next = {SFB_OP_FAST_READ, cmd_addr, 8'h00};
							bits_next = 6'd40;
							state_next = SFB_MAIN;
						end
						else
						begin
							sh_next = {SFB_OP_WRITE_EN, 32'h0000_0000};
							bits_next = 6'd8;
							state_next = SFB_WE_SENT;
						end
					end
				end
				SFB_MAIN:
				begin
					if (kind_reg == SFB_CMD_READ || kind_reg == SFB_CMD_PROG)
					begin
						state_next = SFB_STREAM;
					end
					else
					begin
						cs_next = 1'b1;
						state_next = SFB_IDLE;
					end
				end
				SFB_STREAM:
				begin
					if (cmd_stop)
					begin
						cs_next = 1'b1;
						state_next = SFB_IDLE;
					end
					else if (kind_reg == SFB_CMD_READ)
					begin
						bits_next = 6'd8;
					end
					else
					begin
						wr_ready = 1'b1;
						if (wr_valid)
						begin
							sh_next = {wr_data, 32'h0000_0000};
							bits_next = 6'd8;
						end
					end
				end
				default:
				begin
					state_next = SFB_BOOT;
				end
			endcase
		end
		// read data byte completes on the last falling edge of each stream byte
		if (state_reg == SFB_STREAM && kind_reg == SFB_CMD_READ && bits_reg == 6'd1 && tick && sck_reg)
		begin
			rd_next = rx_reg;
			rdv_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= SFB_BOOT;
			kind_reg <= 2'h0;
			addr_reg <= 24'h00_0000;
			sh_reg <= 40'h00_0000_0000;
			bits_reg <= 6'd0;
			rx_reg <= 8'h00;
			rd_reg <= 8'h00;
			rdv_reg <= 1'b0;
			sck_reg <= 1'b0;
			cs_reg <= 1'b1;
			div_reg <= 3'd0;
			boot_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			addr_reg <= addr_next;
			sh_reg <= sh_next;
			bits_reg <= bits_next;
			rx_reg <= rx_next;
			rd_reg <= rd_next;
			rdv_reg <= rdv_next;
			sck_reg <= sck_next;
			cs_reg <= cs_next;
			div_reg <= div_next;
			boot_reg <= boot_next;
		end
	end

	// ****************************************
	// pins
	// ****************************************
	// hold and write protect have no port at all
	assign flash_serial_clock = sck_reg;
	assign flash_serial_data_out = sh_reg[39];
	assign flash_select_primary_b = cs_reg;
	// enables low while driving; released while reset is held
	assign flash_serial_clock_oe_b = ~rst_b;
	assign flash_serial_data_out_oe_b = ~rst_b;
	assign flash_select_primary_oe_b = ~rst_b;
	assign flash_select_secondary_b = sec_reg;
	assign rd_valid = rdv_reg;
	assign rd_data = rd_reg;
	assign boot_done = boot_reg;
	assign busy = (state_reg != SFB_IDLE);
endmodule : sfb_master

// ===== test/sfb_master_checker.sv
// pin and handshake assertions for the boot master
// assumes binding onto sfb_master
`timescale 1ns/100ps
module sfb_master_checker (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic rd_valid,
	input wire logic boot_done,
	input wire logic busy,
	input wire logic flash_serial_clock,
	input wire logic flash_serial_data_out,
	input wire logic flash_select_primary_b,
	input wire logic flash_select_primary_oe_b
);
	// ****
	// pin and handshake rules
	// ****
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	rel_pins_a: assert property ($rose(rst_b) |-> $past(flash_select_primary_oe_b))
		else $error("select driven in reset");
	drive_pins_a: assert property ($past(rst_b) |-> !flash_select_primary_oe_b)
		else $error("select not driven");
	sck_idle_a: assert property ($changed(flash_select_primary_b) |-> !flash_serial_clock && !$past(flash_serial_clock))
		else $error("select moved, clock high");
	sck_high_a: assert property ($rose(flash_serial_clock) |-> flash_serial_clock [*4] ##1 !flash_serial_clock)
		else $error("clock high time wrong");
	dout_hold_a: assert property (flash_serial_clock && !flash_select_primary_b |-> $stable(flash_serial_data_out))
		else $error("data moved, clock high");
	boot_gate_a: assert property (cmd_ready |-> boot_done && !busy)
		else $error("ready before boot");
	take_busy_a: assert property (cmd_valid && cmd_ready |=> busy && !cmd_ready)
		else $error("command not started");
	rd_pulse_a: assert property (rd_valid |=> !rd_valid)
		else $error("read pulse too long");
	cover property ($rose(boot_done));
	cover property (cmd_valid && cmd_ready);
	cover property (rd_valid);
endmodule : sfb_master_checker
bind sfb_master sfb_master_checker u_chk (.clk_sys, .rst_b, .cmd_valid, .cmd_ready, .rd_valid, .boot_done, .busy,
	.flash_serial_clock, .flash_serial_data_out, .flash_select_primary_b, .flash_select_primary_oe_b);

// ===== test/sfb_flash_model.sv
// behavioural serial flash, mode 0
// assumes one select; hold and write protect pins absent
`timescale 1ns/100ps
module sfb_flash_model (
	input wire logic sck,
	input wire logic cs_b,
	input wire logic mosi,
	output logic miso
);
	// ****
	// flash
	// ****
	logic [7:0] sh, op, oq, bq[$];
	logic latch_set = 1'b0;
	int lq[$], nb = 0, polls = 0;
	initial miso = 1'b0;
	always @(negedge cs_b) nb = 0;
	always @(posedge cs_b)
	begin
		miso = ~miso; // line inverted at deselect, so a stale bit shows
		if (nb > 0) lq.push_back(nb / 8);
		if (op == 8'h05 && latch_set) polls++;
		if (op == 8'h06) polls = 0;
		if (op == 8'h06) latch_set = 1'b1;
		if (op == 8'h02 || op == 8'h20 || op == 8'hC7) latch_set = 1'b0;
	end
	always @(posedge sck)
		if (!cs_b)
		begin
			// edge driven only, so any serial clock rate is served
			sh = {sh[6:0], mosi};
			nb++;
			if (nb % 8 == 0) bq.push_back(sh);
			if (nb == 8) op = sh;
		end
	// latch shows from the second poll on, a slow flash
	always @(negedge sck)
		if (!cs_b)
		begin
			oq = nb % 8 ? oq << 1 : op == 8'h05 ? {6'h00, latch_set && polls > 0, 1'b0} : 8'((nb / 8 - 5) * 7 + 3);
			miso = oq[7];
		end
endmodule : sfb_flash_model

// ===== test/sfb_master_tb.sv
// bench for the serial flash boot master
// assumes the flash model and the pin checker
`timescale 1ns/100ps
module sfb_master_tb;
	import sfb_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, cmd_stop = 1'b0, wr_valid = 1'b0, sec_in = 1'b1;
	logic [1:0] cmd_kind = 2'h0;
	logic [23:0] cmd_addr = 24'h00_0000;
	logic [7:0] wr_data = 8'h00, rd_data, cur[$], ops[4] = '{8'h0B, 8'h02, 8'h20, 8'hC7};
	logic cmd_ready, wr_ready, rd_valid, boot_done, busy, sck, sck_oe_b, dout, dout_oe_b, cs_b, cs_oe_b, sec_b, miso;
	logic [31:0] seed = 32'h0000_0036;
	int err_total = 0, samples_checked = 0;
	wire cs_w = cs_oe_b ? 1'b1 : cs_b;
	wire sck_w = sck_oe_b ? 1'b0 : sck;
	// ****
	// bench
	// ****
	always #5 clk_sys = ~clk_sys;
	sfb_master dut (.clk_sys, .rst_b, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr, .cmd_stop, .wr_valid, .wr_ready,
		.wr_data, .rd_valid, .rd_data, .boot_done, .busy, .flash_select_secondary_in(sec_in),
		.flash_serial_clock(sck), .flash_serial_clock_oe_b(sck_oe_b), .flash_serial_data_out(dout),
		.flash_serial_data_out_oe_b(dout_oe_b), .flash_select_primary_b(cs_b), .flash_select_primary_oe_b(cs_oe_b),
		.flash_select_secondary_b(sec_b), .flash_serial_data_in(miso));
	sfb_flash_model flash (.sck(sck_w), .cs_b(cs_w), .mosi(dout), .miso);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] rd_exp(input int k);
		return 8'(k * 7 + 3);
	endfunction : rd_exp
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic test_done();
		$display("compares %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask : step
	task automatic settle();
		int t;
		t = 0;
		while (!(busy === 1'b0 && boot_done === 1'b1 && cs_w === 1'b1) && t < 30000)
		begin
			step();
			t++;
		end
		chk("idle", 1, t < 30000);
		if (t >= 30000) test_done();
	endtask : settle
	task automatic get_frame(input int n);
		int len;
		len = flash.lq.size() ? flash.lq.pop_front() : -1;
		if (n > 0) chk("frame length", n, len);
		cur.delete();
		repeat (len) cur.push_back(flash.bq.pop_front());
	endtask : get_frame
	task automatic wen_seq();
		get_frame(1);
		chk("write enable", 8'h06, cur[0]);
		repeat (2)
		begin
			get_frame(4);
			chk("status read", 8'h05, cur[0]);
		end
	endtask : wen_seq
	task automatic run_cmd(input logic [1:0] k, input logic [23:0] a, input int n);
		int got, t;
		logic tk;
		logic [7:0] wq[$];
		got = 0;
		t = 0;
		if (k[1]) n = 0;
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_addr = a;
		while (cmd_ready !== 1'b1 && t < 99)
		begin
			step();
			t++;
		end
		chk("command taken", 1, cmd_ready === 1'b1);
		if (cmd_ready !== 1'b1) test_done();
		step();
		cmd_valid = 1'b0;
		wr_valid = k == 2'h1;
		wr_data = 8'(rnd());
		// one-cycle stalls on program data
		while (got < n && t < 9000)
		begin
			tk = wr_valid && wr_ready === 1'b1;
			step();
			t++;
			if (rd_valid === 1'b1)
			begin
				chk("read data", rd_exp(got), rd_data);
				got++;
			end
			if (tk)
			begin
				wq.push_back(wr_data);
				got++;
				wr_data = 8'(rnd());
				wr_valid = rnd() % 2 && got < n;
			end
			else if (k == 2'h1) wr_valid = got < n;
		end
		chk("stream bytes", n, got);
		if (got < n) test_done();
		cmd_stop = !k[1];
		settle();
		cmd_stop = 1'b0;
		if (k != 2'h0) wen_seq();
		get_frame(k == 2'h0 ? 0 : k == 2'h3 ? 1 : 4 + n);
		chk("opcode", ops[k], cur[0]);
		if (k != 2'h3) chk("address", a, {cur[1], cur[2], cur[3]});
		foreach (wq[i]) chk("program data", wq[i], cur[4 + i]);
		if (k == 2'h0) chk("read length", 1, cur.size() >= 5 + n);
	endtask : run_cmd
	initial
	begin
		repeat (3) step();
		sec_in = 1'b0;
		repeat (3) step();
		chk("released pins", 3'h7, {sck_oe_b, dout_oe_b, cs_oe_b});
		chk("secondary select", 1'b0, sec_b);
		rst_b = 1'b1;
		settle();
		wen_seq();
		get_frame(2);
		chk("status write", 16'h0100, {cur[0], cur[1]});
		for (int i = 0; i < 8; i++)
			run_cmd(2'(i), i == 0 ? 24'hFF_FFFF : 24'(rnd()), i < 4 ? 1 : 2 + rnd() % 6);
		test_done();
	end
endmodule : sfb_master_tb
